// ### src/tmc_pkg.sv
/*
 * constants of the two-channel 8-bit compare timer mode control block:
 * register offsets, field positions, reset values, mode and clock codes.
 * assumes an 8-bit register port with 16-bit addresses.
 */
// Overview of operation
// RL1: run off stops and clears counter
// RL2: first timer clock select, six codes
// RL3: second timer clock select, eight codes
// RL4: first timer modes: interval, pwm
// RL5: second timer modes: interval, carrier, pwm
// RL6: level bit sets default output level
// RL7: enable bit gates timer output
// RL8: software keeps mode bits while running
// RL9: software rewrites second compare after restart
// RL10: carrier clock above six times modulator's
// RL11: start companion before flip-flop inversion
// RL12: start companion pwm, then 50% duty
// RL13: companion output clocks regardless of pin
// RL14: pin level uses direction and latch
// RL15: mode registers reset to zero
// RL16: first compare match: interrupt, invert output
// RL17: pwm second compare match: invert, no interrupt
package tmc_pkg;
	// register offsets
	localparam logic [15:0] TIMER0_MODE_CONTROL_OFS = 16'hff69;
	localparam logic [15:0] TIMER1_MODE_CONTROL_OFS = 16'hff6c;
	localparam logic [15:0] TIMER0_FIRST_CMP_OFS = 16'hff70;
	localparam logic [15:0] TIMER0_SECOND_CMP_OFS = 16'hff71;
	localparam logic [15:0] TIMER1_FIRST_CMP_OFS = 16'hff72;
	localparam logic [15:0] TIMER1_SECOND_CMP_OFS = 16'hff73;
	localparam logic [15:0] PORT_CTRL_OFS = 16'hff74;
	localparam logic [15:0] STATUS_OFS = 16'hff75;
	localparam logic [15:0] TIMER0_COUNT_OFS = 16'hff76;
	localparam logic [15:0] TIMER1_COUNT_OFS = 16'hff77;
	// mode register fields
	localparam int RUN_BIT = 7;
	localparam int CKS_LSB = 4;
	localparam int OPS_LSB = 2;
	localparam int LEVEL_BIT = 1;
	localparam int OUTEN_BIT = 0;
	// port control fields: direction 1 = input, buffer off
	localparam int P0_DIR_BIT = 0;
	localparam int P0_LATCH_BIT = 1;
	localparam int P1_DIR_BIT = 2;
	localparam int P1_LATCH_BIT = 3;
	// reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [3:0] PORT_CTRL_RESET = 4'h5;
	// operating modes
	localparam logic [1:0] OP_INTERVAL = 2'h0;
	localparam logic [1:0] OP_CARRIER = 2'h1;
	localparam logic [1:0] OP_PWM = 2'h2;
	// divider exponents of the count clocks
	localparam int PRS_DIV_WIDTH = 12;
	localparam int LS_DIV_WIDTH = 9;
	localparam int T0_EXP1 = 1;
	localparam int T0_EXP2 = 2;
	localparam int T0_EXP3 = 6;
	localparam int T0_EXP4 = 10;
	localparam int T1_EXP1 = 2;
	localparam int T1_EXP2 = 4;
	localparam int T1_EXP3 = 6;
	localparam int T1_EXP4 = 12;
	localparam int T1_LS_EXP5 = 7;
	localparam int T1_LS_EXP6 = 9;
endpackage

// ### src/tmc_sync2.sv
/*
 * two-flop synchroniser with rising-edge pulse.
 * assumes the input is asynchronous to clock_i and slower than half of it.
 */
`timescale 1ns/1ps
`default_nettype none
module tmc_sync2 (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;

	// only sync_ff reads meta_ff; the edge detector sits behind sync_ff
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign level_o = sync_ff;
	assign rise_o = sync_ff & ~last_ff;
endmodule
`default_nettype wire

// ### src/tmc_prescale.sv
/*
 * free-running binary prescaler giving one-cycle ticks at 1/2^k of the
 * enable rate, k = 0..WIDTH. assumes en_i is a one-cycle pulse or level.
 */
`timescale 1ns/1ps
`default_nettype none
module tmc_prescale #(
	parameter int WIDTH = 12
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic en_i,
	output logic [WIDTH:0] tick_o
);
	logic [WIDTH-1:0] cnt_ff;

	// counts enable events; wraps naturally
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_ff <= '0;
		end else if (en_i) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// tick k fires once every 2^k enables, on the all-ones low bits
	assign tick_o[0] = en_i;
	genvar k;
	generate
		for (k = 1; k <= WIDTH; k++) begin : g_tick
			assign tick_o[k] = en_i & (&cnt_ff[k-1:0]);
		end
	endgenerate
endmodule
`default_nettype wire

// ### src/tmc_top.sv
/*
 * two 8-bit compare timers with their mode control registers, compare
 * registers, count clock selection and pin output control.
 * assumes a register port with one-cycle strobes and read data one cycle
 * later; companion and low-speed clock inputs are asynchronous and slow.
 */
`timescale 1ns/1ps
`default_nettype none
module tmc_top (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic companion_counter_a_out_i,
	input wire logic low_speed_osc_clock_i,
	output logic [1:0] timer_match_interrupt_o,
	output logic timer0_out_pin_o,
	output logic timer0_out_pin_oe_o,
	output logic timer1_out_pin_o,
	output logic timer1_out_pin_oe_o
);
	////////////////////////////////////////////////////////////////////////
	// registers of the software side

	logic [7:0] timer0_mode_control_ff;
	logic [7:0] timer1_mode_control_ff;
	logic [3:0] port_ctrl_ff;
	logic [7:0] mode_w [2];
	logic [1:0] wr_cmp0;
	logic [1:0] wr_cmp1;

	// mode registers; rewrites while running are the writer's concern
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			timer0_mode_control_ff <= tmc_pkg::MODE_RESET; // RL15
			timer1_mode_control_ff <= tmc_pkg::MODE_RESET; // RL15
		end else if (wr_i) begin
			if (addr_i == tmc_pkg::TIMER0_MODE_CONTROL_OFS) begin
				timer0_mode_control_ff <= wdata_i;
			end
			if (addr_i == tmc_pkg::TIMER1_MODE_CONTROL_OFS) begin
				timer1_mode_control_ff <= wdata_i;
			end
		end
	end

	// port direction and latch bits for the two shared pins
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			port_ctrl_ff <= tmc_pkg::PORT_CTRL_RESET;
		end else if (wr_i && addr_i == tmc_pkg::PORT_CTRL_OFS) begin
			port_ctrl_ff <= wdata_i[3:0];
		end
	end

	assign mode_w[0] = timer0_mode_control_ff;
	assign mode_w[1] = timer1_mode_control_ff;
	assign wr_cmp0[0] = wr_i && addr_i == tmc_pkg::TIMER0_FIRST_CMP_OFS;
	assign wr_cmp0[1] = wr_i && addr_i == tmc_pkg::TIMER1_FIRST_CMP_OFS;
	assign wr_cmp1[0] = wr_i && addr_i == tmc_pkg::TIMER0_SECOND_CMP_OFS;
	assign wr_cmp1[1] = wr_i && addr_i == tmc_pkg::TIMER1_SECOND_CMP_OFS;

	////////////////////////////////////////////////////////////////////////
	// count clock sources

	logic comp_level;
	logic comp_rise;
	logic ls_level;
	logic ls_rise;
	logic [tmc_pkg::PRS_DIV_WIDTH:0] prs_tick;
	logic [tmc_pkg::LS_DIV_WIDTH:0] ls_tick;
	logic [1:0] cnt_tick;

	// companion output is taken before its pin enable, so it clocks
	// timer 0 whether or not that pin drives
	tmc_sync2 u_comp_sync (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.async_i(companion_counter_a_out_i), // RL13
		.level_o(comp_level),
		.rise_o(comp_rise)
	);

	// low-speed oscillator sampled here; edges become enables
	tmc_sync2 u_ls_sync (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.async_i(low_speed_osc_clock_i),
		.level_o(ls_level),
		.rise_o(ls_rise)
	);

	// peripheral clock divider, shared by both timers
	tmc_prescale #(
		.WIDTH(tmc_pkg::PRS_DIV_WIDTH)
	) u_prs_div (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.en_i(1'b1),
		.tick_o(prs_tick)
	);

	// low-speed divider advances only on oscillator edges
	tmc_prescale #(
		.WIDTH(tmc_pkg::LS_DIV_WIDTH)
	) u_ls_div (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.en_i(ls_rise),
		.tick_o(ls_tick)
	);

	// timer 0 source; prohibited codes give no tick, so the counter holds
	always_comb begin
		case (timer0_mode_control_ff[tmc_pkg::CKS_LSB +: 3]) // RL2
			3'h0: cnt_tick[0] = prs_tick[0];
			3'h1: cnt_tick[0] = prs_tick[tmc_pkg::T0_EXP1];
			3'h2: cnt_tick[0] = prs_tick[tmc_pkg::T0_EXP2];
			3'h3: cnt_tick[0] = prs_tick[tmc_pkg::T0_EXP3];
			3'h4: cnt_tick[0] = prs_tick[tmc_pkg::T0_EXP4];
			3'h5: cnt_tick[0] = comp_rise; // RL13
			default: cnt_tick[0] = 1'b0;
		endcase
	end

	// timer 1 source, all eight codes defined
	always_comb begin
		case (timer1_mode_control_ff[tmc_pkg::CKS_LSB +: 3]) // RL3
			3'h0: cnt_tick[1] = prs_tick[0];
			3'h1: cnt_tick[1] = prs_tick[tmc_pkg::T1_EXP1];
			3'h2: cnt_tick[1] = prs_tick[tmc_pkg::T1_EXP2];
			3'h3: cnt_tick[1] = prs_tick[tmc_pkg::T1_EXP3];
			3'h4: cnt_tick[1] = prs_tick[tmc_pkg::T1_EXP4];
			3'h5: cnt_tick[1] = ls_tick[tmc_pkg::T1_LS_EXP5];
			3'h6: cnt_tick[1] = ls_tick[tmc_pkg::T1_LS_EXP6];
			3'h7: cnt_tick[1] = ls_tick[0];
			default: cnt_tick[1] = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// timer channels

	logic [7:0] cnt_w [2];
	logic [7:0] cmp0_w [2];
	logic [7:0] cmp1_w [2];
	logic [1:0] tout_w;
	logic [1:0] irq_w;

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_tmr
			logic run;
			logic [1:0] op;
			logic is_pwm;
			logic is_car;
			logic hit0;
			logic hit1;
			logic [7:0] cnt_ff;
			logic [7:0] cmp0_ff;
			logic [7:0] cmp1_ff;
			logic [7:0] cmp1_buf_ff;
			logic cmp1_pend_ff;
			logic lvl_ff;
			logic irq_ff;

			assign run = mode_w[i][tmc_pkg::RUN_BIT];
			assign op = mode_w[i][tmc_pkg::OPS_LSB +: 2];
			// carrier exists on timer 1 only; other codes run as interval
			assign is_pwm = (op == tmc_pkg::OP_PWM); // RL4 RL5
			assign is_car = (i == 1) && (op == tmc_pkg::OP_CARRIER); // RL5
			assign hit0 = run && cnt_tick[i] && cnt_ff == cmp0_ff;
			assign hit1 = run && cnt_tick[i] && cnt_ff == cmp1_ff &&
				(is_pwm || is_car);

			// first compare register
			always_ff @(posedge clock_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					cmp0_ff <= tmc_pkg::CMP_RESET;
				end else if (wr_cmp0[i]) begin
					cmp0_ff <= wdata_i;
				end
			end

			// second compare: a write while running waits for the next
			// match; a match in the same cycle as a write keeps the old
			// value and the write stays pending
			always_ff @(posedge clock_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					cmp1_ff <= tmc_pkg::CMP_RESET;
					cmp1_buf_ff <= tmc_pkg::CMP_RESET;
					cmp1_pend_ff <= 1'b0;
				end else if (wr_cmp1[i]) begin
					cmp1_buf_ff <= wdata_i;
					cmp1_pend_ff <= run; // RL9
					if (!run) begin
						cmp1_ff <= wdata_i;
					end
				end else if (cmp1_pend_ff && hit1) begin
					cmp1_ff <= cmp1_buf_ff;
					cmp1_pend_ff <= 1'b0;
				end
			end

			// counter: cleared while stopped, advances on the chosen tick
			always_ff @(posedge clock_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					cnt_ff <= 8'h00;
				end else if (!run) begin
					cnt_ff <= 8'h00; // RL1
				end else if (cnt_tick[i]) begin
					if (is_car ? hit1 : hit0) begin
						cnt_ff <= 8'h00; // RL1
					end else begin
						cnt_ff <= cnt_ff + 8'h01;
					end
				end
			end

			// output level: default while stopped, inverted on a first compare or pwm second compare match, held when both match in one cycle
			always_ff @(posedge clock_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					lvl_ff <= 1'b0;
				end else if (!run) begin
					lvl_ff <= mode_w[i][tmc_pkg::LEVEL_BIT]; // RL6
				end else if (hit0 ^ (hit1 && is_pwm)) begin
					lvl_ff <= ~lvl_ff; // RL16 RL17
				end
			end

			// one-cycle request: first compare in every mode, second compare
			// in carrier mode too; a pwm second compare match raises none
			always_ff @(posedge clock_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					irq_ff <= 1'b0;
				end else begin
					irq_ff <= hit0 | (is_car & hit1); // RL16 RL17
				end
			end

			assign cnt_w[i] = cnt_ff;
			assign cmp0_w[i] = cmp0_ff;
			assign cmp1_w[i] = cmp1_ff;
			assign tout_w[i] = lvl_ff & mode_w[i][tmc_pkg::OUTEN_BIT]; // RL7
			assign irq_w[i] = irq_ff;
		end
	endgenerate

	assign timer_match_interrupt_o = irq_w;

	////////////////////////////////////////////////////////////////////////
	// shared pins: latch must be 0 for the timer signal to show through

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			timer0_out_pin_o <= 1'b0;
			timer0_out_pin_oe_o <= 1'b0;
			timer1_out_pin_o <= 1'b0;
			timer1_out_pin_oe_o <= 1'b0;
		end else begin
			timer0_out_pin_o <= port_ctrl_ff[tmc_pkg::P0_LATCH_BIT] | tout_w[0]; // RL14
			timer0_out_pin_oe_o <= ~port_ctrl_ff[tmc_pkg::P0_DIR_BIT]; // RL14
			timer1_out_pin_o <= port_ctrl_ff[tmc_pkg::P1_LATCH_BIT] | tout_w[1]; // RL14
			timer1_out_pin_oe_o <= ~port_ctrl_ff[tmc_pkg::P1_DIR_BIT]; // RL14
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: data one cycle after the strobe, zero elsewhere

	logic [7:0] nxt_rdata;

	// status shows synchronised source levels too, useful when
	// checking that a slow clock source is actually toggling
	always_comb begin
		nxt_rdata = 8'h00;
		case (addr_i)
			tmc_pkg::TIMER0_MODE_CONTROL_OFS: nxt_rdata = timer0_mode_control_ff;
			tmc_pkg::TIMER1_MODE_CONTROL_OFS: nxt_rdata = timer1_mode_control_ff;
			tmc_pkg::TIMER0_FIRST_CMP_OFS: nxt_rdata = cmp0_w[0];
			tmc_pkg::TIMER0_SECOND_CMP_OFS: nxt_rdata = cmp1_w[0];
			tmc_pkg::TIMER1_FIRST_CMP_OFS: nxt_rdata = cmp0_w[1];
			tmc_pkg::TIMER1_SECOND_CMP_OFS: nxt_rdata = cmp1_w[1];
			tmc_pkg::PORT_CTRL_OFS: nxt_rdata = {4'h0, port_ctrl_ff};
			tmc_pkg::STATUS_OFS: nxt_rdata = {4'h0, ls_level, comp_level, tout_w};
			tmc_pkg::TIMER0_COUNT_OFS: nxt_rdata = cnt_w[0];
			tmc_pkg::TIMER1_COUNT_OFS: nxt_rdata = cnt_w[1];
			default: nxt_rdata = 8'h00;
		endcase
	end

	// read data register; zero when no read was made
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= nxt_rdata;
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ### test/tmc_monitor.sv
/*
 * port checker of the two-timer mode control block.
 * assumes the tmc_top ports and one-cycle register strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module tmc_monitor (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [1:0] timer_match_interrupt_o,
	input wire logic timer0_out_pin_o,
	input wire logic timer0_out_pin_oe_o,
	input wire logic timer1_out_pin_o,
	input wire logic timer1_out_pin_oe_o
);
	logic [7:0] mode0_ff;
	logic [7:0] mode1_ff;
	logic [3:0] port_ff;
	logic [1:0] calm_ff;

	////////////////////////////////////////////////////////////
	// shadows of the control registers; calm saturates three edges after
	// any write, so pipelined outputs have settled before they are judged
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode0_ff <= tmc_pkg::MODE_RESET;
			mode1_ff <= tmc_pkg::MODE_RESET;
			port_ff <= tmc_pkg::PORT_CTRL_RESET;
			calm_ff <= 2'h0;
		end else begin
			if (wr_i && addr_i == tmc_pkg::TIMER0_MODE_CONTROL_OFS) begin
				mode0_ff <= wdata_i;
			end
			if (wr_i && addr_i == tmc_pkg::TIMER1_MODE_CONTROL_OFS) begin
				mode1_ff <= wdata_i;
			end
			if (wr_i && addr_i == tmc_pkg::PORT_CTRL_OFS) begin
				port_ff <= wdata_i[3:0];
			end
			if (wr_i) begin
				calm_ff <= 2'h0;
			end else if (calm_ff != 2'h3) begin
				calm_ff <= calm_ff + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////
	default clocking mon_cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);

	// register port answers
	a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_mode0_readback: assert property (
		rd_i && addr_i == 16'hff69 |=> rdata_o == $past(mode0_ff))
		else $error("timer0 mode register reads wrong");
	a_mode1_readback: assert property (
		rd_i && addr_i == 16'hff6c |=> rdata_o == $past(mode1_ff))
		else $error("timer1 mode register reads wrong");
	// stopped timer 0 holds a zero count and raises no request
	a_stop_clears_count: assert property (
		calm_ff == 2'h3 && rd_i && addr_i == 16'hff76 && !mode0_ff[7] |=> rdata_o == 8'h00)
		else $error("stopped timer0 count not zero");
	a_stop_no_request: assert property (
		calm_ff == 2'h3 && !mode0_ff[7] |-> !timer_match_interrupt_o[0])
		else $error("stopped timer0 raised a request");
	// output level, enable, latch and direction at the pins
	a_stopped_level: assert property (
		calm_ff == 2'h3 && !mode0_ff[7] && mode0_ff[0] && !port_ff[1]
		|-> timer0_out_pin_o == mode0_ff[1])
		else $error("timer0 pin not at default level");
	a_disabled_low: assert property (
		calm_ff == 2'h3 && !mode1_ff[0] && !port_ff[3] |-> !timer1_out_pin_o)
		else $error("disabled timer1 output drives high");
	a_latch_drives_pin: assert property (
		calm_ff == 2'h3 && port_ff[1] |-> timer0_out_pin_o)
		else $error("latch high not seen on pin0");
	a_direction_enable: assert property (
		calm_ff == 2'h3 |-> (timer0_out_pin_oe_o == !port_ff[0])
		&& (timer1_out_pin_oe_o == !port_ff[2]))
		else $error("pin enable disagrees with direction");
endmodule

bind tmc_top tmc_monitor u_tmc_monitor (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.timer_match_interrupt_o(timer_match_interrupt_o),
	.timer0_out_pin_o(timer0_out_pin_o), .timer0_out_pin_oe_o(timer0_out_pin_oe_o),
	.timer1_out_pin_o(timer1_out_pin_o), .timer1_out_pin_oe_o(timer1_out_pin_oe_o)
);
`default_nettype wire

// ### test/test_eight_bit_timer_mode_control.sv
/*
 * self-checking bench of the two-timer mode control block.
 * assumes tmc_top, a 50 MHz clock and slow companion and low-speed sources.
 */
`timescale 1ns/1ps
`default_nettype none
module test_eight_bit_timer_mode_control;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic comp_i = 1'b0;
	logic ls_i = 1'b0;
	logic [7:0] rdata_o;
	logic [1:0] irq;
	logic [1:0] pin;
	logic [1:0] oe;
	int n_mismatch = 0;
	int checks = 0;

	////////////////////////////////////////////////////////////
	// clock, and slow sources whose edges fall on falling clock edges, off the rising ones: 6 and 8 cycles
	always #10 clock_i = ~clock_i;
	always #60 comp_i = ~comp_i;
	always #80 ls_i = ~ls_i;

	tmc_top u_tmc_top (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .companion_counter_a_out_i(comp_i),
		.low_speed_osc_clock_i(ls_i), .timer_match_interrupt_o(irq),
		.timer0_out_pin_o(pin[0]), .timer0_out_pin_oe_o(oe[0]),
		.timer1_out_pin_o(pin[1]), .timer1_out_pin_oe_o(oe[1])
	);

	////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one-cycle write strobe, released at the edge that takes it
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		d = rdata_o;
	endtask

	// clear only the run bit so a running timer never sees other bits move
	task automatic stop(input logic [15:0] ma);
		logic [7:0] v;
		rd(ma, v);
		wr(ma, v & 8'h7f);
	endtask

	// restart timer t and time its match requests; exp 0 means none may come
	task automatic period(input int t, input logic [7:0] m, c0, c1, input int exp,
		output int ones);
		int n;
		int lim;
		logic [15:0] ma;
		logic [15:0] ca;
		ma = t ? 16'hff6c : 16'hff69;
		ca = t ? 16'hff72 : 16'hff70;
		lim = exp ? 20000 : 3000;
		ones = 0;
		stop(ma);
		wr(ca, c0);
		wr(ma, m);
		wr(ca + 16'h0001, c1);
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge clock_i);
				n++;
			end while (irq[t] !== 1'b1 && n < lim);
			if (exp == 0) begin
				chk("idle", 16'(n), 16'(lim));
				return;
			end
			if (n == lim) begin
				n_mismatch++;
				end_sim();
			end
		end
		chk("period", 16'(n), 16'(exp));
		repeat (8) begin
			@(negedge clock_i);
			ones += pin[t];
		end
	endtask

	// stopped timer0 output as seen through latch and direction
	task automatic pins(input logic [7:0] m, pc, input logic ep, eoe);
		stop(16'hff69);
		wr(16'hff69, m);
		wr(16'hff74, pc);
		repeat (3) @(negedge clock_i);
		chk("pin0", pin[0], ep);
		chk("oe0", oe[0], eoe);
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] a;
		logic [7:0] b;
		int ones;
		static int t0_exp[8] = '{2, 4, 8, 128, 2048, 12, 0, 0};
		static int t1_exp[8] = '{2, 8, 32, 128, 8192, 2048, 8192, 16};
		repeat (5) @(posedge clock_i);
		reset_n_i <= 1'b1;
		// reset values, an unmapped place, a readback
		rd(16'hff69, a);
		chk("mode0", a, 8'h00);
		rd(16'hff6c, a);
		chk("mode1", a, 8'h00);
		rd(16'hff00, a);
		chk("unmapped", a, 8'h00);
		wr(16'hff6c, 8'h7e);
		rd(16'hff6c, a);
		chk("mode1 rw", a, 8'h7e);
		// counting at the peripheral clock, then stopping clears the count
		wr(16'hff70, 8'hff);
		wr(16'hff69, 8'h80);
		rd(16'hff76, a);
		rd(16'hff76, b);
		chk("count step", b - a, 16'h0002);
		wr(16'hff69, 8'h00);
		repeat (4) @(posedge clock_i);
		rd(16'hff76, a);
		chk("count stop", a, 8'h00);
		wr(16'hff74, 8'h00);
		// every count clock code of both timers, first compare 1: two ticks a request
		for (int c = 0; c < 8; c++) begin
			period(0, 8'h81 | 8'(c << 4), 8'h01, 8'h00, t0_exp[c], ones);
			period(1, 8'h81 | 8'(c << 4), 8'h01, 8'h00, t1_exp[c], ones);
		end
		// pwm splits each period at the second compare; carrier clears there
		period(0, 8'h89, 8'h07, 8'h02, 8, ones);
		chk("pwm0 high", ones == 3 || ones == 5, 1'b1);
		period(1, 8'h89, 8'h07, 8'h02, 8, ones);
		chk("pwm1 high", ones == 3 || ones == 5, 1'b1);
		// first compare out of reach, so only the second compare clears and requests;
		// the carrier count clock is the undivided peripheral clock, far above any modulator
		period(1, 8'h85, 8'hff, 8'h05, 6, ones);
		// stopped output: level bit, enable bit, then latch and direction
		pins(8'h03, 8'h00, 1'b1, 1'b1);
		pins(8'h01, 8'h00, 1'b0, 1'b1);
		pins(8'h02, 8'h00, 1'b0, 1'b1);
		pins(8'h00, 8'h03, 1'b1, 1'b0);
		end_sim();
	end
endmodule
`default_nettype wire
